// [rtl/flash_program_erase_protect.v]
// Flash program/erase protection: control registers, block select, error protection.
// Assumes an APB master on pclk and CPU event strobes synchronous to pclk.
//
// What this block does
// - Cleared write-enable gate prohibits program and erase on all blocks.
// - Software protection refuses program or erase mode despite set bits.
// - Each block is enabled for program and erase by its select bit.
// - All-zero block select protects every block.
// - APB reset, watchdog reset or standby entry clears control and block select registers; power-on reset does not.
// - A malfunction during program or erase sets the error flag.
// - Error protection keeps register contents but aborts the operation at once.
// - Under error protection, program and erase mode cannot be re-entered.
// - Under error protection, verify bits remain writable and verify mode allowed.
// - Flash read, vector read or fetch during program/erase raises the error.
// - Non-reset exception start during program/erase raises the error.
// - Sleep or software standby during program/erase raises the error.
// - Bus granted away during program/erase raises the error.
// - Only power-on reset clears the error flag and error protection.
// - Interrupts are blocked in error protection while program or erase is set.
// - Flash reads while program or erase is set are flagged invalid.
// - Setup bits sit in control two; program, erase, verify bits in one.
`timescale 1ns/1ps
`include "flash_protect_defs.vh"

module flash_program_erase_protect #(
    parameter NUM_BLOCKS = 8
) (
    // Clock and resets
    input wire pclk,
    input wire presetn,
    input wire por_n,
    input wire wdt_reset,
    input wire standby_entry,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // CPU activity strobes
    input wire flash_read,
    input wire exception_start,
    input wire sleep_exec,
    input wire bus_release,
    // Flash array control
    output reg [NUM_BLOCKS-1:0] prog_enable,
    output reg [NUM_BLOCKS-1:0] erase_enable,
    output reg pverify_mode,
    output reg everify_mode,
    output reg psetup_mode,
    output reg esetup_mode,
    output reg gate_open,
    output reg error_flag,
    output reg irq_block,
    output reg read_invalid
);

    // Gate settle time in whole cycles, rounded up so the wait is never short.
    localparam [15:0] GATE_WAIT_CYC = (`GATE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    // Stored state and its next values.
    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_one_d;
    reg [7:0] ctrl_two_q;
    reg [7:0] ctrl_two_d;
    reg [NUM_BLOCKS-1:0] block_sel_q;
    reg [NUM_BLOCKS-1:0] block_sel_d;
    reg error_q;
    reg error_d;
    reg [15:0] gate_cnt_q;
    reg [15:0] gate_cnt_d;

    // Next values of the registered outputs.
    reg [NUM_BLOCKS-1:0] prog_enable_d;
    reg [NUM_BLOCKS-1:0] erase_enable_d;
    reg pverify_mode_d;
    reg everify_mode_d;
    reg psetup_mode_d;
    reg esetup_mode_d;
    reg gate_open_d;
    reg error_flag_d;
    reg irq_block_d;
    reg read_invalid_d;
    reg [31:0] prdata_d;
    reg pready_d;
    reg pslverr_d;

    wire setup_phase = psel & ~penable;
    wire wr_en = psel & penable & pwrite;
    wire pe_set = ctrl_one_q[`C1_PROG] | ctrl_one_q[`C1_ERASE];
    wire gate = ctrl_one_q[`C1_WEGATE];
    // Blocks are usable only with the gate open and a nonzero selection.
    wire [NUM_BLOCKS-1:0] block_ok = gate ? block_sel_q : {NUM_BLOCKS{1'b0}};
    wire sw_ok = gate & (|block_sel_q);
    wire malfunction = pe_set & (flash_read | exception_start | sleep_exec | bus_release);
    wire clr_regs = wdt_reset | standby_entry;
    // A fresh malfunction acts in the same cycle as a standing error.
    wire err_now = error_q | malfunction;

    function addr_hit;
        input [11:0] a;
        input [11:0] off;
        begin
            addr_hit = (a == off);
        end
    endfunction

    always @* begin
        error_d = error_q;
        if (malfunction) begin
            error_d = 1'b1;
        end
    end

    // Error flag only falls on power-on reset; other resets leave it standing.
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            error_q <= 1'b0;
        end else begin
            error_q <= error_d;
        end
    end

    always @* begin
        ctrl_one_d = ctrl_one_q;
        ctrl_two_d = ctrl_two_q;
        block_sel_d = block_sel_q;
        gate_cnt_d = gate_cnt_q;
        if (clr_regs) begin
            ctrl_one_d = `CTRL_ONE_RST;
            ctrl_two_d = `CTRL_TWO_RST;
            block_sel_d = {NUM_BLOCKS{1'b0}};
            gate_cnt_d = 16'h0000;
        end else begin
            if (wr_en && addr_hit(paddr, `OFF_CTRL_ONE)) begin
                ctrl_one_d = {1'b0, pwdata[`C1_WEGATE], 2'b00, pwdata[3:0]};
            end
            if (wr_en && addr_hit(paddr, `OFF_CTRL_TWO)) begin
                ctrl_two_d = {6'h00, pwdata[`C2_ESETUP], pwdata[`C2_PSETUP]};
            end
            if (wr_en && addr_hit(paddr, `OFF_BLOCK_SEL)) begin
                block_sel_d = pwdata[NUM_BLOCKS-1:0];
            end
            if (!gate) begin
                gate_cnt_d = 16'h0000;
            end else if (gate_cnt_q != GATE_WAIT_CYC) begin
                gate_cnt_d = gate_cnt_q + 16'h0001;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_q <= `CTRL_ONE_RST;
            ctrl_two_q <= `CTRL_TWO_RST;
            block_sel_q <= {NUM_BLOCKS{1'b0}};
            gate_cnt_q <= 16'h0000;
        end else begin
            ctrl_one_q <= ctrl_one_d;
            ctrl_two_q <= ctrl_two_d;
            block_sel_q <= block_sel_d;
            gate_cnt_q <= gate_cnt_d;
        end
    end

    always @* begin
        // Abort at once on a fresh malfunction, and stay out while the error stands.
        if (err_now || !sw_ok) begin
            prog_enable_d = {NUM_BLOCKS{1'b0}};
            erase_enable_d = {NUM_BLOCKS{1'b0}};
        end else begin
            prog_enable_d = ctrl_one_q[`C1_PROG] ? block_ok : {NUM_BLOCKS{1'b0}};
            erase_enable_d = ctrl_one_q[`C1_ERASE] ? block_ok : {NUM_BLOCKS{1'b0}};
        end
        pverify_mode_d = gate & ctrl_one_q[`C1_PVERIFY];
        everify_mode_d = gate & ctrl_one_q[`C1_EVERIFY];
        psetup_mode_d = gate & ctrl_two_q[`C2_PSETUP];
        esetup_mode_d = gate & ctrl_two_q[`C2_ESETUP];
        gate_open_d = gate & (gate_cnt_q == GATE_WAIT_CYC);
        error_flag_d = err_now;
        irq_block_d = err_now & pe_set;
        read_invalid_d = flash_read & pe_set;
    end

    // Array control outputs, registered.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_enable <= {NUM_BLOCKS{1'b0}};
            erase_enable <= {NUM_BLOCKS{1'b0}};
            pverify_mode <= 1'b0;
            everify_mode <= 1'b0;
            psetup_mode <= 1'b0;
            esetup_mode <= 1'b0;
            gate_open <= 1'b0;
            error_flag <= 1'b0;
            irq_block <= 1'b0;
            read_invalid <= 1'b0;
        end else begin
            prog_enable <= prog_enable_d;
            erase_enable <= erase_enable_d;
            pverify_mode <= pverify_mode_d;
            everify_mode <= everify_mode_d;
            psetup_mode <= psetup_mode_d;
            esetup_mode <= esetup_mode_d;
            gate_open <= gate_open_d;
            error_flag <= error_flag_d;
            irq_block <= irq_block_d;
            read_invalid <= read_invalid_d;
        end
    end

    // APB read path: data is latched in the setup cycle, so the access never waits.
    always @* begin
        pready_d = setup_phase;
        pslverr_d = 1'b0;
        prdata_d = 32'h00000000;
        if (setup_phase) begin
            if (addr_hit(paddr, `OFF_CTRL_ONE)) begin
                prdata_d = {24'h000000, ctrl_one_q};
            end else if (addr_hit(paddr, `OFF_CTRL_TWO)) begin
                prdata_d = {24'h000000, error_q, ctrl_two_q[6:0]};
            end else if (addr_hit(paddr, `OFF_BLOCK_SEL)) begin
                prdata_d = {{(32-NUM_BLOCKS){1'b0}}, block_sel_q};
            end else if (addr_hit(paddr, `OFF_STATUS)) begin
                prdata_d = {25'h0000000, read_invalid, irq_block, error_q,
                            everify_mode, pverify_mode, |erase_enable, |prog_enable};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

endmodule // flash_program_erase_protect

// [include/flash_protect_defs.vh]
// Constants for the flash program/erase protection block.
// Assumes a 32-bit APB slave with word-aligned registers.
`ifndef FLASH_PROTECT_DEFS_VH
`define FLASH_PROTECT_DEFS_VH

// Register byte offsets.
`define OFF_CTRL_ONE 12'h000
`define OFF_CTRL_TWO 12'h004
`define OFF_BLOCK_SEL 12'h008
`define OFF_STATUS 12'h00C

// Field positions in flash_ctrl_one.
`define C1_PROG 0
`define C1_ERASE 1
`define C1_PVERIFY 2
`define C1_EVERIFY 3
`define C1_WEGATE 6

// Field positions in flash_ctrl_two.
`define C2_PSETUP 0
`define C2_ESETUP 1
`define C2_ERROR 7

// Field positions in the status register.
`define ST_PROG_ACT 0
`define ST_ERASE_ACT 1
`define ST_PVER_ACT 2
`define ST_EVER_ACT 3
`define ST_ERROR 4
`define ST_IRQ_BLOCK 5
`define ST_READ_BAD 6

// Reset values.
`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define BLOCK_SEL_RST 8'h00
`define BLOCK_NONE 8'h00

// Minimum wait after setting the write-enable gate before loading program data.
`define GATE_WAIT_NS 10000
`define CLK_PERIOD_NS 50

`endif

// [verification/fpep_sva.sv]
// Port checker for the flash program/erase protection block.
// Assumes one pclk domain; bound into every instance of the block.
`timescale 1ns/1ps
module fpep_sva #(parameter NUM_BLOCKS = 8) (
    // Clock, resets and CPU strobes
    input logic pclk, presetn, por_n, wdt_reset, standby_entry,
    input logic flash_read, exception_start, sleep_exec, bus_release,
    // APB
    input logic psel, penable, pready, pslverr,
    // Array control
    input logic [NUM_BLOCKS-1:0] prog_enable, erase_enable,
    input logic psetup_mode, gate_open, error_flag, irq_block, read_invalid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire act = |prog_enable || |erase_enable;
    wire ev = flash_read || exception_start || sleep_exec || bus_release;
    gate_shut_a: assert property (!gate_open ##1 !gate_open |-> !act)
        else $error("array enabled with gate closed");
    err_hold_a: assert property (error_flag ##1 por_n |-> error_flag)
        else $error("error flag lost without power-on reset");
    err_abort_a: assert property (error_flag |=> !act)
        else $error("operation not aborted under error");
    fault_a: assert property (ev && act |-> ##[0:1] error_flag)
        else $error("fault during operation not flagged");
    irq_gate_a: assert property (irq_block |-> error_flag)
        else $error("interrupts blocked outside error state");
    read_bad_a: assert property (flash_read && act |=> read_invalid)
        else $error("array read not marked invalid");
    hw_clear_a: assert property (wdt_reset || standby_entry |-> ##2 !act && !psetup_mode)
        else $error("controls survive reset or standby");
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    slv_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    cover property ($rose(error_flag));
    cover property (act);
    cover property (pslverr);
endmodule // fpep_sva
bind flash_program_erase_protect fpep_sva #(.NUM_BLOCKS(NUM_BLOCKS)) fpep_sva_i (.*);

// [verification/testbench.sv]
// Self-checking bench for the flash protection block, driven over APB.
// Assumes zero-wait APB answers and a 200-cycle gate delay.
`timescale 1ns/1ps
`include "flash_protect_defs.vh"
module testbench;
    reg pclk = 0, presetn = 0, por_n = 0, wdt_reset = 0, standby_entry = 0;
    reg psel = 0, penable = 0, pwrite = 0, slv;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, rd;
    reg [3:0] ev = 4'h0;
    reg [7:0] blk, c1;
    wire [31:0] prdata;
    wire pready, pslverr, pvm, evm, psm, esm, gate, err, irqb, rinv;
    wire [7:0] pe, ee;
    integer err_count = 0, num_checks = 0, cyc = 0, k;
    always #25 pclk = ~pclk;
    flash_program_erase_protect flash_program_erase_protect_i (.pclk(pclk),
        .presetn(presetn), .por_n(por_n), .wdt_reset(wdt_reset), .psel(psel),
        .standby_entry(standby_entry), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_read(ev[0]), .exception_start(ev[1]), .sleep_exec(ev[2]), .bus_release(ev[3]),
        .prog_enable(pe), .erase_enable(ee), .pverify_mode(pvm), .everify_mode(evm),
        .psetup_mode(psm), .esetup_mode(esm), .gate_open(gate), .error_flag(err),
        .irq_block(irqb), .read_invalid(rinv));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            slv = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    // Expected enables: program on even passes, erase on odd ones.
    function [15:0] en_exp(input integer i, input [7:0] b);
        en_exp = i[0] ? {8'h00, b} : {b, 8'h00};
    endfunction
    task results;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count = err_count + 1;
            results;
        end
    end
    initial begin
        blk = $urandom(13);
        tick(3);
        presetn <= 1;
        por_n <= 1;
        apb(0, `OFF_CTRL_ONE, 0);
        chk(rd, 0);
        apb(0, 12'h010, 0);
        chk(slv, 1);
        apb(1, `OFF_CTRL_ONE, 32'h03);
        apb(1, `OFF_BLOCK_SEL, 32'hFF);
        tick(2);
        chk({pe, ee, gate}, 0);
        for (k = 0; k < 4; k = k + 1) begin
            blk = $urandom | 8'h01;
            c1 = k[0] ? 8'h42 : 8'h41;
            apb(1, `OFF_BLOCK_SEL, 0);
            apb(1, `OFF_CTRL_ONE, c1);
            tick(205);
            chk({pe, ee}, 0);
            chk(gate, 1);
            apb(1, `OFF_BLOCK_SEL, blk);
            apb(1, `OFF_CTRL_TWO, 32'h03);
            tick(2);
            chk({psm, esm, pe, ee}, {2'b11, en_exp(k, blk)});
            @(posedge pclk) ev <= 4'h1 << k;
            @(posedge pclk) ev <= 4'h0;
            #1 chk({err, rinv}, {1'b1, k == 0});
            tick(1);
            chk({pe, ee, irqb}, 17'h00001);
            apb(0, `OFF_CTRL_ONE, 0);
            chk(rd[7:0], c1);
            apb(1, `OFF_CTRL_ONE, c1 | 8'h0C);
            apb(1, `OFF_CTRL_TWO, 0);
            tick(2);
            chk({pe, ee, pvm, evm}, 18'h00003);
            apb(0, `OFF_CTRL_TWO, 0);
            chk(rd[7], 1);
            @(posedge pclk) {wdt_reset, standby_entry} <= k[0] ? 2'b01 : 2'b10;
            @(posedge pclk) {wdt_reset, standby_entry} <= 2'b00;
            tick(2);
            apb(0, `OFF_CTRL_ONE, 0);
            chk({rd, err}, 33'h1);
            presetn <= 0;
            tick(3);
            presetn <= 1;
            tick(2);
            chk(err, 1);
            por_n <= 0;
            tick(3);
            por_n <= 1;
            tick(1);
            chk(err, 0);
            $display("test %0d done", k);
        end
        results;
    end
endmodule // testbench
